// ===== design/irq_ctrl_pkg.sv
// constants, register map and source numbering of the interrupt controller
// Overview of operation
// - twelve sources, each high or low level
// - per-source enable, pending flag, priority, vector
// - request needs global and source enable
// - vectors eight bytes apart from 0003H
// - external groups trigger rising, falling or both
// - timer 0/1 flags auto-clear on acknowledge
// - timer 2 flag cleared by software only
// - converter flag cleared on start, set done
// - serial frame-done flag cleared by software
// - pulse overflow flag auto-clears on acknowledge
// - groups merge 3, 4, 6 pins
// - external edges wake from stop mode
// - base tick and touch also wake
// - same level: smallest index wins
// - high preempts low; same level waits
// - one instruction after return before grant
package irq_ctrl_pkg;
	localparam int NUM_SRC = 12;
	localparam int GRP0_PINS = 3;
	localparam int GRP1_PINS = 4;
	localparam int GRP2_PINS = 6;
	localparam int EXT_PINS = GRP0_PINS + GRP1_PINS + GRP2_PINS;
	localparam int GRP1_LSB = GRP0_PINS;
	localparam int GRP2_LSB = GRP0_PINS + GRP1_PINS;
	localparam logic [15:0] VECTOR_BASE = 16'h0003;
	localparam logic [15:0] VECTOR_STEP = 16'h0008;
	// source indices in query order
	localparam int SRC_EXT0 = 0;
	localparam int SRC_TIMER0 = 1;
	localparam int SRC_EXT1 = 2;
	localparam int SRC_TIMER1 = 3;
	localparam int SRC_UART = 4;
	localparam int SRC_TIMER2 = 5;
	localparam int SRC_CONV = 6;
	localparam int SRC_SERIAL = 7;
	localparam int SRC_PULSE = 8;
	localparam int SRC_BASE = 9;
	localparam int SRC_EXT2 = 10;
	localparam int SRC_TOUCH = 11;
	// flags that hardware clears when the core takes the vector
	localparam logic [11:0] AUTO_CLEAR_MASK = 12'hF0F;
	// register byte offsets
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_ENABLE = 8'h04;
	localparam logic [7:0] REG_PRIORITY = 8'h08;
	localparam logic [7:0] REG_PENDING = 8'h0C;
	localparam logic [7:0] REG_RISE_EN = 8'h10;
	localparam logic [7:0] REG_FALL_EN = 8'h14;
	localparam logic [7:0] REG_EVT_STATUS = 8'h18;
	localparam logic [7:0] REG_EVT_MASK = 8'h1C;
	localparam logic [7:0] REG_SERVICE = 8'h20;
	localparam logic [7:0] REG_CONV_CTRL = 8'h24;
	localparam int CTRL_GIE_BIT = 0;
	localparam int CONV_DONE_BIT = 5;
	// event status bits
	localparam int EVT_GRANT = 0;
	localparam int EVT_WAKE = 1;
	localparam int EVT_RETURN = 2;
	localparam int NUM_EVT = 3;
	// reset values
	localparam logic [11:0] SRC_RESET = 12'h000;
	localparam logic [12:0] EDGE_RESET = 13'h0000;
	localparam logic [2:0] EVT_RESET = 3'h0;
	localparam logic [15:0] VECTOR_RESET = 16'h0000;
	localparam logic [31:0] DATA_RESET = 32'h0000_0000;
endpackage

// ===== design/irq_ctrl.sv
// twelve-source two-level interrupt controller with wishbone register slave
`timescale 1ns/1ps
`default_nettype none
module irq_ctrl (
	input wire logic clk_i,
	input wire logic rst_i,
	// wishbone classic slave
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [7:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	// external pin groups
	input wire logic [2:0] ext_irq_group0_i,
	input wire logic [3:0] ext_irq_group1_i,
	input wire logic [5:0] ext_irq_group2_i,
	// peripheral event pulses
	input wire logic timer0_overflow_i,
	input wire logic timer1_overflow_i,
	input wire logic timer2_overflow_i,
	input wire logic uart_rx_tx_done_i,
	input wire logic conversion_start_i,
	input wire logic conversion_done_i,
	input wire logic serial_frame_done_i,
	input wire logic pulse_overflow_i,
	input wire logic base_tick_i,
	input wire logic touch_overflow_i,
	// core side
	input wire logic irq_ack_i,
	input wire logic reti_i,
	input wire logic instr_done_i,
	input wire logic stop_mode_i,
	output logic irq_req_o,
	output logic [15:0] irq_vector_o,
	output logic irq_level_o,
	output logic wakeup_o,
	output logic irq_o
);
	localparam int N = irq_ctrl_pkg::NUM_SRC;

	// lowest set index, valid flag in bit 4
	function automatic logic [4:0] pick_lowest(input logic [11:0] req);
		logic [4:0] r;
		r = 5'h00;
		for (int i = N - 1; i >= 0; i--) begin
			if (req[i]) begin
				r = {1'b1, 4'(i)};
			end
		end
		return r;
	endfunction

	function automatic logic [31:0] merge(input logic [31:0] old,
			input logic [31:0] wr, input logic [3:0] sel);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (sel[b]) begin
				r[8*b +: 8] = wr[8*b +: 8];
			end
		end
		return r;
	endfunction

	function automatic logic [15:0] vector_of(input logic [3:0] idx);
		return 16'(irq_ctrl_pkg::VECTOR_BASE
			+ 16'(irq_ctrl_pkg::VECTOR_STEP * {12'h000, idx}));
	endfunction

	logic global_irq_enable;
	logic [11:0] enable;
	logic [11:0] priority_select_reg;
	logic [11:0] pending;
	logic [12:0] ext_rising_enable;
	logic [12:0] ext_falling_enable;
	logic [2:0] evt_status;
	logic [2:0] evt_mask;
	logic active_low;
	logic active_high;
	logic post_return;
	logic [12:0] pins_prev;
	logic [3:0] grant_idx;

	// bus decode; lanes merge into the old value, no slicing of a call
	localparam logic [31:0] DATA_ZERO = irq_ctrl_pkg::DATA_RESET;
	logic bus_req;
	logic bus_wr;
	logic [31:0] wr_word;
	logic [31:0] en_word, pri_word, rise_word, fall_word;
	always_comb begin
		bus_req = cyc_i & stb_i;
		bus_wr = bus_req & we_i & ack_o;
		wr_word = merge(DATA_ZERO, dat_i, sel_i);
		en_word = merge({20'h0, enable}, dat_i, sel_i);
		pri_word = merge({20'h0, priority_select_reg}, dat_i, sel_i);
		rise_word = merge({19'h0, ext_rising_enable}, dat_i, sel_i);
		fall_word = merge({19'h0, ext_falling_enable}, dat_i, sel_i);
	end

	// external edge detection; pins are synchronous to clk_i
	logic [12:0] pins;
	logic [12:0] pin_hit;
	logic ext0_edge;
	logic ext1_edge;
	logic ext2_edge;
	always_comb begin
		pins = {ext_irq_group2_i, ext_irq_group1_i, ext_irq_group0_i};
		pin_hit = (pins & ~pins_prev & ext_rising_enable)
			| (~pins & pins_prev & ext_falling_enable);
		ext0_edge = |pin_hit[irq_ctrl_pkg::GRP1_LSB-1:0];
		ext1_edge = |pin_hit[irq_ctrl_pkg::GRP2_LSB-1:
			irq_ctrl_pkg::GRP1_LSB];
		ext2_edge = |pin_hit[irq_ctrl_pkg::EXT_PINS-1:
			irq_ctrl_pkg::GRP2_LSB];
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pins_prev <= irq_ctrl_pkg::EDGE_RESET;
		end else begin
			pins_prev <= pins;
		end
	end

	// hardware set events per source
	logic [11:0] set_evt;
	always_comb begin
		set_evt = 12'h000;
		set_evt[irq_ctrl_pkg::SRC_EXT0] = ext0_edge;
		set_evt[irq_ctrl_pkg::SRC_TIMER0] = timer0_overflow_i;
		set_evt[irq_ctrl_pkg::SRC_EXT1] = ext1_edge;
		set_evt[irq_ctrl_pkg::SRC_TIMER1] = timer1_overflow_i;
		set_evt[irq_ctrl_pkg::SRC_UART] = uart_rx_tx_done_i;
		set_evt[irq_ctrl_pkg::SRC_TIMER2] = timer2_overflow_i;
		set_evt[irq_ctrl_pkg::SRC_CONV] = conversion_done_i;
		set_evt[irq_ctrl_pkg::SRC_SERIAL] = serial_frame_done_i;
		set_evt[irq_ctrl_pkg::SRC_PULSE] = pulse_overflow_i;
		set_evt[irq_ctrl_pkg::SRC_BASE] = base_tick_i;
		set_evt[irq_ctrl_pkg::SRC_EXT2] = ext2_edge;
		set_evt[irq_ctrl_pkg::SRC_TOUCH] = touch_overflow_i;
	end

	// arbitration
	logic ack_take;
	logic [11:0] req;
	logic [4:0] hi_pick;
	logic [4:0] lo_pick;
	logic win_valid;
	logic win_level;
	logic [3:0] win_idx;
	always_comb begin
		ack_take = irq_req_o & irq_ack_i;
		req = pending & enable & {N{global_irq_enable}};
		hi_pick = pick_lowest(req & priority_select_reg);
		lo_pick = pick_lowest(req & ~priority_select_reg);
		win_valid = 1'b0;
		win_level = 1'b0;
		win_idx = 4'h0;
		if (post_return) begin
			win_valid = 1'b0;
		end else if (hi_pick[4] && !active_high) begin
			win_valid = 1'b1;
			win_level = 1'b1;
			win_idx = hi_pick[3:0];
		end else if (lo_pick[4] && !active_high && !active_low) begin
			win_valid = 1'b1;
			win_idx = lo_pick[3:0];
		end
	end

	// request strobe and vector; dropped the cycle after acknowledge
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			irq_req_o <= 1'b0;
			irq_vector_o <= irq_ctrl_pkg::VECTOR_RESET;
			irq_level_o <= 1'b0;
			grant_idx <= 4'h0;
		end else if (ack_take) begin
			irq_req_o <= 1'b0;
		end else begin
			irq_req_o <= win_valid;
			irq_vector_o <= vector_of(win_idx);
			irq_level_o <= win_level;
			grant_idx <= win_idx;
		end
	end

	// in-service levels
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			active_low <= 1'b0;
			active_high <= 1'b0;
		end else if (ack_take) begin
			if (irq_level_o) begin
				active_high <= 1'b1;
			end else begin
				active_low <= 1'b1;
			end
		end else if (reti_i) begin
			// return ends the innermost handler, high nests inside low
			if (active_high) begin
				active_high <= 1'b0;
			end else begin
				active_low <= 1'b0;
			end
		end
	end

	// hold off grants until one instruction has run after a return
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			post_return <= 1'b0;
		end else if (reti_i) begin
			post_return <= 1'b1;
		end else if (instr_done_i) begin
			post_return <= 1'b0;
		end
	end

	// pending flags; a hardware set wins over any clear
	logic [11:0] clr_evt;
	always_comb begin
		clr_evt = 12'h000;
		if (ack_take) begin
			clr_evt[grant_idx] = irq_ctrl_pkg::AUTO_CLEAR_MASK[grant_idx];
		end
		if (bus_wr && adr_i == irq_ctrl_pkg::REG_PENDING) begin
			clr_evt = clr_evt | wr_word[11:0];
		end
		if (bus_wr && adr_i == irq_ctrl_pkg::REG_CONV_CTRL
				&& sel_i[0] && !dat_i[irq_ctrl_pkg::CONV_DONE_BIT]) begin
			clr_evt[irq_ctrl_pkg::SRC_CONV] = 1'b1;
		end
		if (conversion_start_i) begin
			clr_evt[irq_ctrl_pkg::SRC_CONV] = 1'b1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pending <= irq_ctrl_pkg::SRC_RESET;
		end else begin
			pending <= (pending & ~clr_evt) | set_evt;
		end
	end

	// software configuration
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			global_irq_enable <= 1'b0;
			enable <= irq_ctrl_pkg::SRC_RESET;
			priority_select_reg <= irq_ctrl_pkg::SRC_RESET;
			ext_rising_enable <= irq_ctrl_pkg::EDGE_RESET;
			ext_falling_enable <= irq_ctrl_pkg::EDGE_RESET;
			evt_mask <= irq_ctrl_pkg::EVT_RESET;
		end else if (bus_wr) begin
			case (adr_i)
				irq_ctrl_pkg::REG_CTRL: begin
					if (sel_i[0]) begin
						global_irq_enable <= dat_i[irq_ctrl_pkg::CTRL_GIE_BIT];
					end
				end
				irq_ctrl_pkg::REG_ENABLE: begin
					enable <= en_word[11:0];
				end
				irq_ctrl_pkg::REG_PRIORITY: begin
					priority_select_reg <= pri_word[11:0];
				end
				irq_ctrl_pkg::REG_RISE_EN: begin
					ext_rising_enable <= rise_word[12:0];
				end
				irq_ctrl_pkg::REG_FALL_EN: begin
					ext_falling_enable <= fall_word[12:0];
				end
				irq_ctrl_pkg::REG_EVT_MASK: begin
					if (sel_i[0]) begin
						evt_mask <= dat_i[2:0];
					end
				end
				default: begin
				end
			endcase
		end
	end

	// wake from stop: external edges, base tick, touch counter
	logic wake_evt;
	always_comb begin
		wake_evt = stop_mode_i & (ext0_edge | ext1_edge | ext2_edge
			| base_tick_i | touch_overflow_i);
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wakeup_o <= 1'b0;
		end else begin
			wakeup_o <= wake_evt;
		end
	end

	// sticky event status, write one to clear, set wins
	logic [2:0] evt_set;
	logic [2:0] evt_clr;
	always_comb begin
		evt_set = 3'h0;
		evt_set[irq_ctrl_pkg::EVT_GRANT] = ack_take;
		evt_set[irq_ctrl_pkg::EVT_WAKE] = wake_evt;
		evt_set[irq_ctrl_pkg::EVT_RETURN] = reti_i;
		evt_clr = 3'h0;
		if (bus_wr && adr_i == irq_ctrl_pkg::REG_EVT_STATUS && sel_i[0]) begin
			evt_clr = dat_i[2:0];
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			evt_status <= irq_ctrl_pkg::EVT_RESET;
			irq_o <= 1'b0;
		end else begin
			evt_status <= (evt_status & ~evt_clr) | evt_set;
			irq_o <= |(((evt_status & ~evt_clr) | evt_set) & evt_mask);
		end
	end

	// read mux
	logic [31:0] rd_word;
	always_comb begin
		rd_word = DATA_ZERO;
		case (adr_i)
			irq_ctrl_pkg::REG_CTRL:
				rd_word[irq_ctrl_pkg::CTRL_GIE_BIT] = global_irq_enable;
			irq_ctrl_pkg::REG_ENABLE: rd_word[11:0] = enable;
			irq_ctrl_pkg::REG_PRIORITY: rd_word[11:0] = priority_select_reg;
			irq_ctrl_pkg::REG_PENDING: rd_word[11:0] = pending;
			irq_ctrl_pkg::REG_RISE_EN: rd_word[12:0] = ext_rising_enable;
			irq_ctrl_pkg::REG_FALL_EN: rd_word[12:0] = ext_falling_enable;
			irq_ctrl_pkg::REG_EVT_STATUS: rd_word[2:0] = evt_status;
			irq_ctrl_pkg::REG_EVT_MASK: rd_word[2:0] = evt_mask;
			irq_ctrl_pkg::REG_SERVICE:
				rd_word[22:0] = {post_return, irq_level_o, irq_req_o,
					irq_vector_o, grant_idx};
			irq_ctrl_pkg::REG_CONV_CTRL:
				rd_word[irq_ctrl_pkg::CONV_DONE_BIT] =
					pending[irq_ctrl_pkg::SRC_CONV];
			default: rd_word = DATA_ZERO;
		endcase
	end

	// one wait state: ack follows the request by one edge, then drops
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_o <= 1'b0;
			dat_o <= irq_ctrl_pkg::DATA_RESET;
		end else begin
			ack_o <= bus_req & ~ack_o;
			dat_o <= rd_word;
		end
	end
endmodule // irq_ctrl
`default_nettype wire

// ===== test/irq_ctrl_props.sv
// port assertions of the interrupt controller
`timescale 1ns/1ps
`default_nettype none
module irq_ctrl_props (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic ack_o,
	input wire logic irq_ack_i,
	input wire logic reti_i,
	input wire logic instr_done_i,
	input wire logic stop_mode_i,
	input wire logic base_tick_i,
	input wire logic touch_overflow_i,
	input wire logic irq_req_o,
	input wire logic [15:0] irq_vector_o,
	input wire logic wakeup_o,
	input wire logic irq_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	a_ack_one_wait: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
		else $error("ack late");
	a_ack_single: assert property (ack_o |=> !ack_o)
		else $error("ack too long");
	a_vector_grid: assert property (irq_req_o |->
		irq_vector_o[2:0] == 3'h3 && irq_vector_o <= 16'h005B)
		else $error("bad vector");
	a_take_drops_req: assert property (irq_req_o && irq_ack_i |=> !irq_req_o)
		else $error("request held after take");
	a_return_holds: assert property (reti_i ##1 !instr_done_i |=> !irq_req_o)
		else $error("grant right after return");
	a_wake_in_stop: assert property (wakeup_o |-> $past(stop_mode_i))
		else $error("wake outside stop");
	a_wake_tick: assert property (
		stop_mode_i && (base_tick_i || touch_overflow_i) |=> wakeup_o)
		else $error("tick did not wake");
	a_reset_quiet: assert property ($past(rst_i) |->
		!irq_req_o && !wakeup_o && !irq_o && !ack_o)
		else $error("output busy after reset");
endmodule // irq_ctrl_props
`default_nettype wire

// ===== test/core_model.sv
// behavioural core: takes vectors, serves, returns
`timescale 1ns/1ps
`default_nettype none
module core_model (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic req_i,
	input wire logic [15:0] vec_i,
	input wire logic [1:0] dly_i,
	output logic ack_o,
	output logic reti_o,
	output logic done_o,
	output logic [15:0] last_vec_o,
	output logic [7:0] grants_o,
	output logic [1:0] depth_o
);
	logic [3:0] cnt;
	logic [1:0] wcnt;
	logic [1:0] tail;
	always_ff @(posedge clk_i) begin
		ack_o <= 1'b0;
		reti_o <= 1'b0;
		// done three cycles after the return pulse, so the hold after return shows
		tail <= {tail[0], reti_o};
		done_o <= tail[1];
		if (rst_i) begin
			cnt <= 4'h0;
			wcnt <= 2'h0;
			depth_o <= 2'h0;
			grants_o <= 8'h00;
			last_vec_o <= 16'h0000;
		end else if (ack_o && req_i) begin
			last_vec_o <= vec_i;
			grants_o <= grants_o + 8'h01;
			depth_o <= depth_o + 2'h1;
			cnt <= 4'h0;
			wcnt <= 2'h0;
		end else begin
			// nesting allowed: the controller decides preemption
			ack_o <= req_i && !ack_o && wcnt >= dly_i;
			wcnt <= req_i && wcnt != 2'h3 ? wcnt + 2'h1 : wcnt;
			cnt <= depth_o != 2'h0 ? cnt + 4'h1 : 4'h0;
			if (depth_o != 2'h0 && cnt == 4'hF) begin
				reti_o <= 1'b1;
				depth_o <= depth_o - 2'h1;
			end
		end
	end
endmodule // core_model
`default_nettype wire

// ===== test/testbench.sv
// self-checking bench of the interrupt controller
`timescale 1ns/1ps
`default_nettype none
module testbench;
	localparam logic [7:0] PEND = irq_ctrl_pkg::REG_PENDING;
	logic clk, rst, cyc, stb, we, cst, stop;
	logic ack, req, lvl, wake, irq, mack, reti, done;
	logic [7:0] adr, grants;
	logic [31:0] dat, dout, rdata;
	logic [11:0] ev, exp_p;
	logic [12:0] pins;
	logic [1:0] dly, depth;
	logic [15:0] vec, lastv;
	int err_total, n_tests, k, m, e;
	irq_ctrl uut (.clk_i(clk), .rst_i(rst), .cyc_i(cyc), .stb_i(stb),
		.we_i(we), .adr_i(adr), .sel_i(4'hF), .dat_i(dat), .dat_o(dout),
		.ack_o(ack), .ext_irq_group0_i(pins[2:0]),
		.ext_irq_group1_i(pins[6:3]), .ext_irq_group2_i(pins[12:7]),
		.timer0_overflow_i(ev[1]), .timer1_overflow_i(ev[3]),
		.timer2_overflow_i(ev[5]), .uart_rx_tx_done_i(ev[4]),
		.conversion_start_i(cst), .conversion_done_i(ev[6]),
		.serial_frame_done_i(ev[7]), .pulse_overflow_i(ev[8]),
		.base_tick_i(ev[9]), .touch_overflow_i(ev[11]), .irq_ack_i(mack),
		.reti_i(reti), .instr_done_i(done), .stop_mode_i(stop),
		.irq_req_o(req), .irq_vector_o(vec), .irq_level_o(lvl),
		.wakeup_o(wake), .irq_o(irq));
	core_model core (.clk_i(clk), .rst_i(rst), .req_i(req), .vec_i(vec),
		.dly_i(dly), .ack_o(mack), .reti_o(reti), .done_o(done),
		.last_vec_o(lastv), .grants_o(grants), .depth_o(depth));
	function automatic logic [15:0] vecof(input int i);
		return 16'h0003 + 16'(i) * 16'h0008;
	endfunction
	function automatic logic autoc(input int i);
		return !(i inside {[4:7]});
	endfunction
	task automatic conclude();
		$display("checks %0d mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] x);
		n_tests++;
		if (g !== x) begin
			err_total++;
			$display("BAD %0t got %h exp %h", $time, g, x);
		end
	endtask
	task automatic bus(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		int i;
		{cyc, stb, we, adr, dat} <= {2'b11, w, a, d};
		for (i = 0; i < 20 && ack !== 1'b1; i++) @(posedge clk);
		rdata = dout;
		if (ack !== 1'b1) begin
			err_total++;
			conclude();
		end
		{cyc, stb} <= 2'b00;
		@(posedge clk);
	endtask
	task automatic pulse(input logic [11:0] p);
		ev <= p;
		@(posedge clk);
		ev <= 12'h000;
	endtask
	task automatic wgrant(input logic [7:0] n);
		int i;
		for (i = 0; i < 400 && grants !== n; i++) @(posedge clk);
		if (grants !== n) begin
			err_total++;
			conclude();
		end
	endtask
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	initial begin
		{rst, cyc, stb, we, cst, stop} = 6'h20;
		{adr, dat, ev, pins, dly} = '0;
		err_total = 0;
		n_tests = 0;
		void'($urandom(31));
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		for (k = 0; k < 5; k++) begin
			bus(1'b0, k == 4 ? 8'h3C : 8'(4 * k), 0);
			chk(rdata, 0);
		end
		$display("reset values done");
		bus(1'b1, irq_ctrl_pkg::REG_ENABLE, 32'hFFF);
		pulse(12'h002);
		repeat (5) @(posedge clk);
		chk(req, 0);
		bus(1'b1, irq_ctrl_pkg::REG_CTRL, 1);
		wgrant(8'h01);
		chk(lastv, vecof(1));
		bus(1'b0, PEND, 0);
		chk(rdata, 0);
		bus(1'b1, irq_ctrl_pkg::REG_CTRL, 0);
		bus(1'b1, irq_ctrl_pkg::REG_RISE_EN, 32'h1FFF);
		pins[$urandom % 3] <= 1'b1;
		pins[3 + $urandom % 4] <= 1'b1;
		pins[7 + $urandom % 6] <= 1'b1;
		pulse(12'hBFA);
		repeat (4) @(posedge clk);
		bus(1'b1, irq_ctrl_pkg::REG_CTRL, 1);
		exp_p = 12'hFFF;
		for (k = 0; k < 12; k++) begin
			dly <= 2'($urandom % 4);
			wgrant(8'(k + 2));
			chk(lastv, vecof(k));
			if (autoc(k)) exp_p[k] = 1'b0;
			bus(1'b0, PEND, 0);
			chk(rdata, {20'h0, exp_p});
			if (!autoc(k)) bus(1'b1, PEND, 32'h1 << k);
			exp_p[k] = 1'b0;
		end
		$display("arbitration order done");
		bus(1'b1, irq_ctrl_pkg::REG_PRIORITY, 32'h008);
		pulse(12'h002);
		wgrant(8'h0E);
		chk(lvl, 0);
		pulse(12'h028);
		wgrant(8'h0F);
		chk(lvl, 1);
		chk(lastv, vecof(3));
		chk(depth, 2);
		wgrant(8'h10);
		chk(lastv, vecof(5));
		bus(1'b1, PEND, 32'h020);
		$display("preemption done");
		bus(1'b1, irq_ctrl_pkg::REG_CTRL, 0);
		pulse(12'h040);
		bus(1'b0, irq_ctrl_pkg::REG_CONV_CTRL, 0);
		chk(rdata[5], 1);
		cst <= 1'b1;
		@(posedge clk);
		cst <= 1'b0;
		bus(1'b0, PEND, 0);
		chk(rdata[6], 0);
		pulse(12'h040);
		bus(1'b1, irq_ctrl_pkg::REG_CONV_CTRL, 0);
		bus(1'b0, PEND, 0);
		chk(rdata[6], 0);
		pins <= 13'h0000;
		for (m = 1; m < 4; m++) begin
			bus(1'b1, irq_ctrl_pkg::REG_RISE_EN, m[0] ? 32'h1F80 : 0);
			bus(1'b1, irq_ctrl_pkg::REG_FALL_EN, m[1] ? 32'h1F80 : 0);
			k = 7 + $urandom % 6;
			for (e = 0; e < 2; e++) begin
				bus(1'b1, PEND, 32'hFFF);
				pins[k] <= ~pins[k];
				repeat (4) @(posedge clk);
				bus(1'b0, PEND, 0);
				chk(rdata[10], m[e]);
			end
		end
		$display("edge modes done");
		bus(1'b1, irq_ctrl_pkg::REG_EVT_STATUS, 32'h7);
		bus(1'b1, irq_ctrl_pkg::REG_EVT_MASK, 32'h2);
		stop <= 1'b1;
		pins[k] <= 1'b1;
		for (e = 0; e < 8 && wake !== 1'b1; e++) @(posedge clk);
		chk(wake, 1);
		bus(1'b1, irq_ctrl_pkg::REG_EVT_STATUS, 32'h2);
		@(posedge clk);
		chk(irq, 0);
		pulse(12'hA00);
		@(posedge clk);
		chk(wake, 1);
		chk(irq, 1);
		bus(1'b1, irq_ctrl_pkg::REG_EVT_MASK, 0);
		pulse(12'h200);
		repeat (3) @(posedge clk);
		chk(irq, 0);
		stop <= 1'b0;
		$display("wake and event irq done");
		conclude();
	end
endmodule // testbench
bind irq_ctrl irq_ctrl_props props (.clk_i(clk_i), .rst_i(rst_i),
	.cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o), .irq_ack_i(irq_ack_i),
	.reti_i(reti_i), .instr_done_i(instr_done_i),
	.stop_mode_i(stop_mode_i), .base_tick_i(base_tick_i),
	.touch_overflow_i(touch_overflow_i), .irq_req_o(irq_req_o),
	.irq_vector_o(irq_vector_o), .wakeup_o(wakeup_o), .irq_o(irq_o));
`default_nettype wire
